/* File: logic/ctrl_cfg.svh */
// Constants shared by both ends of the control-byte link.
`ifndef CTRL_CFG_SVH
`define CTRL_CFG_SVH

// ----------------------------------------
// Link
// ----------------------------------------
`define DEF_PORT_ADDR   8'h40
`define NUM_GROUPS      7
`define NUM_SLOTS       8
`define GRP_NONE        3'h7
`define GRP_SRCH        3'h3
`define GRP_CMD         3'h6

// ----------------------------------------
// Pointer bits of each group's base byte
// ----------------------------------------
`define PTR_MASK_G0     8'h78
`define PTR_MASK_G1     8'h40
`define PTR_MASK_G2     8'h40
`define PTR_MASK_G3     8'h18
`define PTR_MASK_G4     8'h1C
`define PTR_MASK_NONE   8'h00

// ----------------------------------------
// Commands and control bits
// ----------------------------------------
`define CMD_ENABLE      8'h87
`define CMD_DISABLE     8'h83
`define CMD_REINIT      8'h8B
`define CMD_INT_EN      8'hAB
`define CMD_INT_DIS     8'hAF
`define G3_INT_EN_BIT   5
`define G3_DMA_EN_BIT   6

// ----------------------------------------
// Status byte
// ----------------------------------------
`define ST_RDY_BIT      0
`define ST_INT_BIT      1
`define ST_MATCH_BIT    4
`define ST_EOB_BIT      5

// ----------------------------------------
// Host APB map and interrupt bits
// ----------------------------------------
`define OFS_WDATA       8'h00
`define OFS_RDCMD       8'h04
`define OFS_RDATA       8'h08
`define OFS_STATE       8'h0C
`define OFS_IRQ_STAT    8'h10
`define OFS_IRQ_MASK    8'h14
`define OFS_GRANT       8'h18
`define IRQ_W           3
`define IRQ_DONE_BIT    0
`define IRQ_REQ_BIT     1
`define IRQ_REFUSE_BIT  2

`endif

/* File: logic/ctrl_pkg.sv */
// Types of the two ends of the control-byte link: controller state and transfer mode, host state.
package ctrl_pkg;

  typedef enum logic [1:0] {
    DISABLED, INACTIVE, SUSPENDED, OPERATING
  } dev_state_type;

  typedef enum logic [1:0] {
    MODE_BYTE, MODE_CONTINUOUS, MODE_BURST, MODE_SPARE
  } xfer_mode_type;

  typedef enum logic [1:0] {
    H_IDLE, H_DIS, H_OP, H_CAP
  } host_state_type;

endpackage : ctrl_pkg

/* File: logic/ctrl_link_if.sv */
// Interface joining the host end and the controller end.
`timescale 1ns/100ps
interface ctrl_link_if;
  logic [7:0] io_addr;
  logic       io_iorq;
  logic       io_wr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       bus_request_n;
  logic       bus_ack_in_n;

  modport device (
    input  io_addr, io_iorq, io_wr, io_wdata, bus_ack_in_n,
    output io_rdata, bus_request_n
  );

  modport host (
    output io_addr, io_iorq, io_wr, io_wdata, bus_ack_in_n,
    input  io_rdata, bus_request_n
  );
endinterface : ctrl_link_if

/* File: logic/ctrl_byte_device.sv */
// Controller end: control-byte sequencer and enable state.
//
// Added by the designer: readback of programmed bytes over peek_group and peek_slot.
`timescale 1ns/100ps
`include "ctrl_cfg.svh"
module ctrl_byte_device #(
  parameter logic [7:0] PORT_ADDR = `DEF_PORT_ADDR
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Link to the host
  ctrl_link_if.device                 link,
  // Transfer engine
  input  wire logic                   rdy,
  input  wire logic                   eob,
  input  wire logic                   auto_restart,
  input  wire logic                   byte_match,
  input  wire ctrl_pkg::xfer_mode_type mode,
  // Readback of programmed bytes
  input  wire logic [2:0]             peek_group,
  input  wire logic [2:0]             peek_slot,
  output logic [7:0]                  peek_byte,
  // State
  output ctrl_pkg::dev_state_type     state,
  output logic                        int_pending
);

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic [2:0] decode_group(input logic [7:0] b);
    logic [2:0] g;
    g = `GRP_NONE;
    if (!b[7]) begin
      if (b[1:0] != 2'h0) begin
        g = 3'h0;
      end else if (b[2]) begin
        g = 3'h1;
      end else begin
        g = 3'h2;
      end
    end else begin
      case (b[1:0])
        2'h0: g = `GRP_SRCH;
        2'h1: g = 3'h4;
        2'h2: g = (b[2] || b[6]) ? `GRP_NONE : 3'h5;
        default: g = `GRP_CMD;
      endcase
    end
    return g;
  endfunction : decode_group

  function automatic logic [7:0] pointer_mask(input logic [2:0] g);
    logic [7:0] m;
    case (g)
      3'h0: m = `PTR_MASK_G0;
      3'h1: m = `PTR_MASK_G1;
      3'h2: m = `PTR_MASK_G2;
      3'h3: m = `PTR_MASK_G3;
      3'h4: m = `PTR_MASK_G4;
      default: m = `PTR_MASK_NONE;
    endcase
    return m;
  endfunction : pointer_mask

  function automatic logic [2:0] lowest_bit(input logic [7:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = `NUM_SLOTS - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : lowest_bit

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Slot 0 of each group holds its base byte; pointer bits never use bit 0
  logic [7:0]              regs_q [`NUM_GROUPS][`NUM_SLOTS];
  logic [7:0]              regs_d [`NUM_GROUPS][`NUM_SLOTS];
  ctrl_pkg::dev_state_type state_q, state_d;
  logic [2:0]              seq_grp_q, seq_grp_d;
  logic [7:0]              seq_mask_q, seq_mask_d;
  logic                    prev_cmd_q, prev_cmd_d;
  logic                    int_en_q, int_en_d;
  logic                    int_pend_q, int_pend_d;
  logic                    match_seen_q, match_seen_d;
  logic                    eob_seen_q, eob_seen_d;
  logic                    req_n_q, req_n_d;
  logic [7:0]              rdata_q, rdata_d;
  logic [7:0]              peek_q, peek_d;

  logic       cs;
  logic       master;
  logic       host_wr;
  logic       host_rd;
  logic [2:0] grp;
  logic [2:0] slot;
  logic       is_cmd;
  logic       enable;
  logic       stop_event;

  assign cs      = link.io_iorq && (link.io_addr == PORT_ADDR);
  assign master  = (state_q == ctrl_pkg::OPERATING) || (state_q == ctrl_pkg::SUSPENDED);
  // While it holds the bus any port cycle is its own transfer, never programming
  assign host_wr = cs && link.io_wr && !master;
  assign host_rd = cs && !link.io_wr && !master;
  assign grp     = decode_group(link.io_wdata);
  assign slot    = lowest_bit(seq_mask_q);
  assign is_cmd  = (grp == `GRP_CMD);
  assign enable  = (is_cmd && link.io_wdata == `CMD_ENABLE) ||
                   (grp == `GRP_SRCH && link.io_wdata[`G3_DMA_EN_BIT]);
  assign stop_event = (eob && !auto_restart) || byte_match;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    regs_d       = regs_q;
    state_d      = state_q;
    seq_grp_d    = seq_grp_q;
    seq_mask_d   = seq_mask_q;
    prev_cmd_d   = prev_cmd_q;
    int_en_d     = int_en_q;
    int_pend_d   = int_pend_q;
    match_seen_d = match_seen_q;
    eob_seen_d   = eob_seen_q;
    rdata_d      = rdata_q;

    if (host_wr) begin
      if (seq_mask_q != 8'h00) begin
        // Associated bytes fill in ascending pointer-bit order
        regs_d[seq_grp_q][slot] = link.io_wdata;
        seq_mask_d[slot]        = 1'b0;
        prev_cmd_d              = 1'b0;
        state_d                 = ctrl_pkg::DISABLED;
      end else if (grp != `GRP_NONE) begin
        regs_d[grp][0] = link.io_wdata;
        seq_grp_d      = grp;
        seq_mask_d     = link.io_wdata & pointer_mask(grp);
        prev_cmd_d     = is_cmd;
        if (enable) begin
          state_d = ctrl_pkg::INACTIVE;
        end else if (is_cmd && link.io_wdata == `CMD_REINIT && prev_cmd_q) begin
          state_d = state_q;
        end else begin
          state_d = ctrl_pkg::DISABLED;
        end
        if (grp == `GRP_SRCH && link.io_wdata[`G3_INT_EN_BIT]) begin
          int_en_d = 1'b1;
        end
        if (is_cmd && link.io_wdata == `CMD_INT_EN) begin
          int_en_d = 1'b1;
        end
        if (is_cmd && link.io_wdata == `CMD_INT_DIS) begin
          int_en_d = 1'b0;
        end
        if (is_cmd && link.io_wdata == `CMD_REINIT) begin
          match_seen_d = 1'b0;
          eob_seen_d   = 1'b0;
          int_pend_d   = 1'b0;
        end
      end else begin
        prev_cmd_d = 1'b0;
        state_d    = ctrl_pkg::DISABLED;
      end
    end else begin
      case (state_q)
        ctrl_pkg::INACTIVE: begin
          if (!req_n_q && !link.bus_ack_in_n) begin
            state_d = ctrl_pkg::OPERATING;
          end
        end
        ctrl_pkg::OPERATING: begin
          if (stop_event) begin
            state_d = ctrl_pkg::INACTIVE;
          end else if (link.bus_ack_in_n && mode != ctrl_pkg::MODE_CONTINUOUS) begin
            state_d = ctrl_pkg::INACTIVE;
          end else if (!rdy && mode == ctrl_pkg::MODE_CONTINUOUS) begin
            state_d = ctrl_pkg::SUSPENDED;
          end
        end
        ctrl_pkg::SUSPENDED: begin
          if (stop_event || link.bus_ack_in_n) begin
            state_d = ctrl_pkg::INACTIVE;
          end else if (rdy) begin
            state_d = ctrl_pkg::OPERATING;
          end
        end
        default: begin
          state_d = ctrl_pkg::DISABLED;
        end
      endcase
    end

    // Events set after any clear so a coincident event is kept
    if (master && byte_match) begin
      match_seen_d = 1'b1;
    end
    if (master && eob) begin
      eob_seen_d = 1'b1;
    end
    if (int_en_d && master && (byte_match || eob)) begin
      int_pend_d = 1'b1;
    end

    if (host_rd) begin
      rdata_d                = 8'h00;
      rdata_d[`ST_RDY_BIT]   = rdy;
      rdata_d[`ST_INT_BIT]   = int_pend_q;
      rdata_d[`ST_MATCH_BIT] = match_seen_q;
      rdata_d[`ST_EOB_BIT]   = eob_seen_q;
    end
  end

  // Request only in an enabled state; disabled always holds it high
  always_comb begin
    case (state_d)
      ctrl_pkg::INACTIVE:  req_n_d = !rdy;
      ctrl_pkg::OPERATING: req_n_d = 1'b0;
      ctrl_pkg::SUSPENDED: req_n_d = 1'b0;
      default:             req_n_d = 1'b1;
    endcase
  end

  always_comb begin
    if (peek_group < 3'(`NUM_GROUPS)) begin
      peek_d = regs_q[peek_group][peek_slot];
    end else begin
      peek_d = 8'h00;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Programmed bytes clear to zero only for determinism; software must load them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int g = 0; g < `NUM_GROUPS; g++) begin
        for (int s = 0; s < `NUM_SLOTS; s++) begin
          regs_q[g][s] <= 8'h00;
        end
      end
      state_q      <= ctrl_pkg::DISABLED;
      seq_grp_q    <= 3'h0;
      seq_mask_q   <= 8'h00;
      prev_cmd_q   <= 1'b0;
      int_en_q     <= 1'b0;
      int_pend_q   <= 1'b0;
      match_seen_q <= 1'b0;
      eob_seen_q   <= 1'b0;
      req_n_q      <= 1'b1;
      rdata_q      <= 8'h00;
      peek_q       <= 8'h00;
    end else begin
      regs_q       <= regs_d;
      state_q      <= state_d;
      seq_grp_q    <= seq_grp_d;
      seq_mask_q   <= seq_mask_d;
      prev_cmd_q   <= prev_cmd_d;
      int_en_q     <= int_en_d;
      int_pend_q   <= int_pend_d;
      match_seen_q <= match_seen_d;
      eob_seen_q   <= eob_seen_d;
      req_n_q      <= req_n_d;
      rdata_q      <= rdata_d;
      peek_q       <= peek_d;
    end
  end

  assign link.io_rdata      = rdata_q;
  assign link.bus_request_n = req_n_q;
  assign peek_byte          = peek_q;
  assign state              = state_q;
  assign int_pending        = int_pend_q;

endmodule : ctrl_byte_device

/* File: logic/ctrl_byte_host.sv */
// Host end: APB-programmed issuer of control bytes and status reads.
`timescale 1ns/100ps
`include "ctrl_cfg.svh"
module ctrl_byte_host #(
  parameter logic [7:0] PORT_ADDR = `DEF_PORT_ADDR
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Link to the controller
  ctrl_link_if.host        link
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ctrl_pkg::host_state_type hst_q, hst_d;
  logic [`IRQ_W-1:0] stat_q, stat_d;
  logic [`IRQ_W-1:0] mask_q, mask_d;
  logic              grant_en_q, grant_en_d;
  logic              enabled_q, enabled_d;
  logic [7:0]        byte_q, byte_d;
  logic              op_wr_q, op_wr_d;
  logic [7:0]        rd_byte_q, rd_byte_d;
  logic              iorq_q, iorq_d;
  logic              wr_q, wr_d;
  logic [7:0]        wdata_q, wdata_d;
  logic              ack_n_q, ack_n_d;
  logic              req_seen_q;
  logic              pready_q, pready_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              pslverr_q, pslverr_d;
  logic              irq_q, irq_d;

  logic access;
  logic wr_go;
  logic mapped;
  logic start;

  assign access = psel && penable && pready_q;
  assign wr_go  = access && pwrite;
  assign mapped = paddr inside {`OFS_WDATA, `OFS_RDCMD, `OFS_RDATA, `OFS_STATE,
                                `OFS_IRQ_STAT, `OFS_IRQ_MASK, `OFS_GRANT};
  assign start  = wr_go && (paddr == `OFS_WDATA || paddr == `OFS_RDCMD);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    hst_d      = hst_q;
    stat_d     = stat_q;
    mask_d     = mask_q;
    grant_en_d = grant_en_q;
    enabled_d  = enabled_q;
    byte_d     = byte_q;
    op_wr_d    = op_wr_q;
    rd_byte_d  = rd_byte_q;
    iorq_d     = 1'b0;
    wr_d       = 1'b0;
    wdata_d    = wdata_q;

    if (wr_go && paddr == `OFS_IRQ_STAT) begin
      stat_d = stat_q & ~pwdata[`IRQ_W-1:0];
    end
    if (wr_go && paddr == `OFS_IRQ_MASK) begin
      mask_d = pwdata[`IRQ_W-1:0];
    end
    if (wr_go && paddr == `OFS_GRANT) begin
      grant_en_d = pwdata[0];
    end

    case (hst_q)
      ctrl_pkg::H_IDLE: begin
        if (start && ack_n_q) begin
          byte_d  = pwdata[7:0];
          op_wr_d = (paddr == `OFS_WDATA);
          // An enabled controller must be disabled before any other access
          if (enabled_q && !(op_wr_d && byte_d == `CMD_DISABLE)) begin
            hst_d = ctrl_pkg::H_DIS;
          end else begin
            hst_d = ctrl_pkg::H_OP;
          end
        end else if (start) begin
          stat_d[`IRQ_REFUSE_BIT] = 1'b1;
        end
      end
      ctrl_pkg::H_DIS: begin
        iorq_d    = 1'b1;
        wr_d      = 1'b1;
        wdata_d   = `CMD_DISABLE;
        enabled_d = 1'b0;
        hst_d     = ctrl_pkg::H_OP;
      end
      ctrl_pkg::H_OP: begin
        iorq_d  = 1'b1;
        wr_d    = op_wr_q;
        wdata_d = byte_q;
        if (op_wr_q) begin
          if (byte_q == `CMD_ENABLE) begin
            enabled_d = 1'b1;
          end else if (byte_q == `CMD_DISABLE) begin
            enabled_d = 1'b0;
          end
          hst_d = ctrl_pkg::H_IDLE;
          stat_d[`IRQ_DONE_BIT] = 1'b1;
        end else begin
          hst_d = ctrl_pkg::H_CAP;
        end
      end
      ctrl_pkg::H_CAP: begin
        // Status byte lands one cycle after the read cycle; capturing earlier takes a stale byte
        if (!iorq_q) begin
          rd_byte_d             = link.io_rdata;
          hst_d                 = ctrl_pkg::H_IDLE;
          stat_d[`IRQ_DONE_BIT] = 1'b1;
        end
      end
      default: begin
        hst_d = ctrl_pkg::H_IDLE;
      end
    endcase

    if (!link.bus_request_n && !req_seen_q) begin
      stat_d[`IRQ_REQ_BIT] = 1'b1;
    end

    // Grant only when the next host state is idle, which a write's own port cycle can overlap: the host cannot reach a bus master
    ack_n_d = !(grant_en_q && !link.bus_request_n && hst_d == ctrl_pkg::H_IDLE);
    irq_d   = |(stat_d & mask_d);

    pready_d  = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d  = 32'h0000_0000;
    if (pready_d && !pwrite) begin
      case (paddr)
        `OFS_RDATA:    prdata_d = {24'h00_0000, rd_byte_q};
        `OFS_STATE:    prdata_d = {28'h000_0000, enabled_q, !link.bus_request_n, !ack_n_q,
                                   hst_q != ctrl_pkg::H_IDLE};
        `OFS_IRQ_STAT: prdata_d = {29'h0000_0000, stat_q};
        `OFS_IRQ_MASK: prdata_d = {29'h0000_0000, mask_q};
        `OFS_GRANT:    prdata_d = {31'h0000_0000, grant_en_q};
        default:       prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hst_q      <= ctrl_pkg::H_IDLE;
      stat_q     <= 3'h0;
      mask_q     <= 3'h0;
      grant_en_q <= 1'b0;
      enabled_q  <= 1'b0;
      byte_q     <= 8'h00;
      op_wr_q    <= 1'b0;
      rd_byte_q  <= 8'h00;
      iorq_q     <= 1'b0;
      wr_q       <= 1'b0;
      wdata_q    <= 8'h00;
      ack_n_q    <= 1'b1;
      req_seen_q <= 1'b0;
      pready_q   <= 1'b0;
      prdata_q   <= 32'h0000_0000;
      pslverr_q  <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      hst_q      <= hst_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      grant_en_q <= grant_en_d;
      enabled_q  <= enabled_d;
      byte_q     <= byte_d;
      op_wr_q    <= op_wr_d;
      rd_byte_q  <= rd_byte_d;
      iorq_q     <= iorq_d;
      wr_q       <= wr_d;
      wdata_q    <= wdata_d;
      ack_n_q    <= ack_n_d;
      req_seen_q <= !link.bus_request_n;
      pready_q   <= pready_d;
      prdata_q   <= prdata_d;
      pslverr_q  <= pslverr_d;
      irq_q      <= irq_d;
    end
  end

  assign link.io_addr      = PORT_ADDR;
  assign link.io_iorq      = iorq_q;
  assign link.io_wr        = wr_q;
  assign link.io_wdata     = wdata_q;
  assign link.bus_ack_in_n = ack_n_q;
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign irq               = irq_q;

endmodule : ctrl_byte_host

/* File: testbench/ctrl_link_monitor.sv */
// Checker of the link between the host end and the controller end.
`timescale 1ns/100ps
`include "ctrl_cfg.svh"
module ctrl_link_monitor #(
  parameter logic [7:0] PORT_ADDR = `DEF_PORT_ADDR
) (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Link
  input wire logic [7:0] io_addr,
  input wire logic       io_iorq,
  input wire logic       io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       bus_request_n,
  input wire logic       bus_ack_in_n
);
  // ----------------------------------------
  // Last byte seen was an enable
  // ----------------------------------------
  logic wr_byte;
  logic en_q;
  logic en_d;
  assign wr_byte = io_iorq && io_wr;
  always_comb begin
    en_d = en_q;
    if (wr_byte) begin
      en_d = (io_wdata == `CMD_ENABLE);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_d;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_plain_byte;
    wr_byte && io_wdata != `CMD_ENABLE;
  endsequence
  sequence s_request_up;
    ##[1:2] bus_request_n;
  endsequence
  a_reset_idle_link: assert property ($rose(presetn) |-> bus_request_n && bus_ack_in_n && !io_iorq
    && io_rdata == 8'h00) else $error("link not idle after reset");
  a_single_port: assert property (io_iorq |-> io_addr == PORT_ADDR)
    else $error("port cycle off the port address");
  a_disable_first: assert property (wr_byte && en_q |-> io_wdata == `CMD_DISABLE)
    else $error("byte sent to enabled controller without disable");
  // The enable sets the flag on the same edge the request falls, so the flag is already updated
  a_request_needs_enable: assert property ($fell(bus_request_n) |-> en_q)
    else $error("bus request without enable");
  a_byte_drops_request: assert property (s_plain_byte |-> s_request_up)
    else $error("bus request kept after disabling byte");
  a_grant_needs_request: assert property ($fell(bus_ack_in_n) |-> !$past(bus_request_n))
    else $error("grant without request");
  a_quiet_on_grant: assert property (!bus_ack_in_n && $past(!bus_ack_in_n) |-> !io_iorq)
    else $error("port cycle while controller holds bus");
  a_status_holds: assert property (!($past(io_iorq) && !$past(io_wr)) |-> $stable(io_rdata))
    else $error("status byte changed without read");
endmodule : ctrl_link_monitor

/* File: testbench/tb_top.sv */
// Testbench joining host and controller ends, driven over APB.
`timescale 1ns/100ps
`include "ctrl_cfg.svh"
module tb_top;
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  logic                    rdy;
  logic                    eob;
  logic                    auto_restart;
  logic                    byte_match;
  ctrl_pkg::xfer_mode_type mode;
  logic [2:0]              peek_group;
  logic [2:0]              peek_slot;
  logic [7:0]              peek_byte;
  ctrl_pkg::dev_state_type dev_state;
  logic                    int_pending;
  logic [31:0]             rd;
  logic                    err;
  integer                  mismatches;
  integer                  checked;
  integer                  i;
  logic [7:0]              prog [8] = '{8'h19, 8'h34, 8'h12, 8'h44, 8'h5A, 8'h98, 8'h11, 8'h22};
  logic [2:0]              pg [8] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h3, 3'h3, 3'h3};
  logic [2:0]              ps [8] = '{3'h0, 3'h3, 3'h4, 3'h0, 3'h6, 3'h0, 3'h3, 3'h4};
  logic [7:0]              cmds [4] = '{`CMD_DISABLE, `CMD_REINIT, `CMD_INT_EN, `CMD_INT_DIS};
  ctrl_link_if link();
  ctrl_byte_host ctrl_byte_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link));
  ctrl_byte_device ctrl_byte_device_i (.pclk(pclk), .presetn(presetn), .link(link), .rdy(rdy),
    .eob(eob), .auto_restart(auto_restart), .byte_match(byte_match), .mode(mode),
    .peek_group(peek_group), .peek_slot(peek_slot), .peek_byte(peek_byte), .state(dev_state),
    .int_pending(int_pending));
  ctrl_link_monitor ctrl_link_monitor_i (.pclk(pclk), .presetn(presetn), .io_addr(link.io_addr),
    .io_iorq(link.io_iorq), .io_wr(link.io_wr), .io_wdata(link.io_wdata), .io_rdata(link.io_rdata),
    .bus_request_n(link.bus_request_n), .bus_ack_in_n(link.bus_ack_in_n));
  always #5 pclk = ~pclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic give_up();
    mismatches++;
    end_of_test();
  endtask : give_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One idle cycle first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) give_up();
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdv(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdv
  task automatic send(input logic [7:0] b);
    integer n;
    wr(`OFS_WDATA, {24'h0, b});
    n = 0;
    do begin
      apb(1'b0, `OFS_STATE, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 30);
    if (rd[0] !== 1'b0) give_up();
  endtask : send
  task automatic wst(input ctrl_pkg::dev_state_type s);
    integer n;
    for (n = 0; n < 300 && dev_state !== s; n++) @(posedge pclk);
    chk({30'h0, dev_state}, {30'h0, s});
    if (dev_state !== s) end_of_test();
  endtask : wst
  task automatic peek(input logic [2:0] g, input logic [2:0] s, input logic [7:0] e);
    peek_group <= g;
    peek_slot <= s;
    repeat (2) @(posedge pclk);
    chk({24'h0, peek_byte}, {24'h0, e});
  endtask : peek
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rdy, eob, auto_restart, byte_match, peek_group, peek_slot} = '0;
    mode = ctrl_pkg::MODE_BYTE;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wst(ctrl_pkg::DISABLED);
    chk({31'h0, link.bus_request_n}, 32'h1);
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, err}, 32'h1);
    rdv(`OFS_IRQ_STAT, 32'h0);
    for (i = 0; i < 8; i++) send(prog[i]);
    for (i = 0; i < 8; i++) peek(pg[i], ps[i], prog[i]);
    send(`CMD_INT_EN);
    wr(`OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_STAT, 32'h7);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h2);
    rdy <= 1'b1;
    // Eob, match, then lost grant each end the transfer; the match pass first suspends
    for (i = 0; i < 3; i++) begin
      wr(`OFS_GRANT, 32'h1);
      send(`CMD_ENABLE);
      wst(ctrl_pkg::OPERATING);
      chk({31'h0, irq}, 32'h1);
      if (i == 0) begin
        wr(`OFS_WDATA, 32'h1);
        rdv(`OFS_IRQ_STAT, 32'h7);
      end
      if (i == 1) begin
        mode <= ctrl_pkg::MODE_CONTINUOUS;
        rdy <= 1'b0;
        wst(ctrl_pkg::SUSPENDED);
        rdy <= 1'b1;
        wst(ctrl_pkg::OPERATING);
        mode <= ctrl_pkg::MODE_BYTE;
      end
      eob <= (i == 0);
      byte_match <= (i == 1);
      if (i == 2) wr(`OFS_GRANT, 32'h0);
      wst(ctrl_pkg::INACTIVE);
      chk({31'h0, int_pending}, 32'h1);
      eob <= 1'b0;
      byte_match <= 1'b0;
      wr(`OFS_GRANT, 32'h0);
      wst(ctrl_pkg::INACTIVE);
      send(8'h01);
      wst(ctrl_pkg::DISABLED);
      repeat (4) @(posedge pclk);
      wst(ctrl_pkg::DISABLED);
      chk({31'h0, link.bus_request_n}, 32'h1);
      wr(`OFS_IRQ_STAT, 32'h7);
    end
    rdy <= 1'b0;
    for (i = 0; i < 4; i++) begin
      send(`CMD_ENABLE);
      wst(ctrl_pkg::INACTIVE);
      send(cmds[i]);
      wst(ctrl_pkg::DISABLED);
    end
    // Group-3 enable leaves the host unaware, so a lone reinit reaches an enabled device
    send(8'hC0);
    wst(ctrl_pkg::INACTIVE);
    send(`CMD_REINIT);
    wst(ctrl_pkg::DISABLED);
    rdy <= 1'b1;
    send(`CMD_REINIT);
    wr(`OFS_RDCMD, 32'h0);
    repeat (4) @(posedge pclk);
    apb(1'b0, `OFS_RDATA, 32'h0);
    chk(rd & 32'h33, 32'h01);
    send(`CMD_ENABLE);
    wst(ctrl_pkg::INACTIVE);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    wst(ctrl_pkg::DISABLED);
    chk({31'h0, link.bus_request_n}, 32'h1);
    presetn <= 1'b1;
    peek(3'h0, 3'h3, 8'h00);
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    give_up();
  end
endmodule : tb_top
